// [nand_host.sv]
// Purpose: host sequencer driving a byte-wide nand flash through its strobes
// Assumes: ready_busy_out sampled synchronously; pull-up resolved outside
// Notes: one request at a time; address op sends all four cycles itself
`include "nand_host_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module nand_host (
	input wire logic clk,
	input wire logic rst_n,
	input wire nand_host_pkg::req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic refused,
	output var nand_host_pkg::pins_t pins,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic ready_busy_out,
	output logic device_busy
);
	// ==========================================================
	// request state
	nand_host_pkg::state_t state;
	nand_host_pkg::state_t next_state;
	nand_host_pkg::req_t cur;
	logic [`CNT_W-1:0] cnt;
	logic [2:0] addr_idx;
	logic [1:0] prog_count [0:`PAGES_PER_BLOCK-1];
	logic [2:0] block_count;

	// address byte of cycle i, top bits of last cycle forced low
	function automatic logic [7:0] addr_byte(input logic [25:0] a, input logic [2:0] i);
		unique case (i)
			3'h0: addr_byte = a[7:0];
			3'h1: addr_byte = a[15:8];
			3'h2: addr_byte = a[23:16];
			default: addr_byte = {6'h00, a[25:24]} & `LAST_ADDR_MASK;
		endcase
	endfunction

	// ==========================================================
	// decode
	wire is_write_op = (cur.op == nand_host_pkg::OP_CMD) || (cur.op == nand_host_pkg::OP_ADDR)
		|| (cur.op == nand_host_pkg::OP_WDATA);
	// command codes that start or chain a program
	wire is_prog_cmd = (req.op == nand_host_pkg::OP_CMD) && (req.data == `CMD_PROG
		|| req.data == `CMD_DUMMY_PROG || req.data == `CMD_MULTI_PROG);
	wire is_multi_cmd = (req.op == nand_host_pkg::OP_CMD) && (req.data == `CMD_DUMMY_PROG);
	wire [4:0] page_sel = req.addr[`PAGE_IDX_HI:`PAGE_IDX_LO] & `PAGES_PER_BLOCK_MASK;
	wire over_prog = is_prog_cmd && (prog_count[page_sel] == `MAX_PROG_PER_PAGE);
	wire over_multi = is_multi_cmd && (block_count == `MAX_MULTI_BLOCKS - 3'h1);
	wire is_erase_cmd = (req.op == nand_host_pkg::OP_CMD) && (req.data == `CMD_ERASE_GO);
	// only reset and status reads may go out while the device is busy
	wire allowed_busy = (req.op == nand_host_pkg::OP_CMD)
		&& (req.data == `CMD_RESET || req.data == `CMD_STATUS || req.data == `CMD_STATUS_ALT);
	wire busy_block = !ready_busy_out && !allowed_busy;
	wire take = req_valid && req_ready;
	assign req_ready = (state == nand_host_pkg::ST_IDLE) && !busy_block && !over_prog
		&& !over_multi;
	assign device_busy = !ready_busy_out;
	wire refuse_now = req_valid && (state == nand_host_pkg::ST_IDLE) && !busy_block
		&& (over_prog || over_multi);
	wire cnt_done = (cnt == '0);

	// next state
	always_comb begin
		next_state = state;
		unique case (state)
			nand_host_pkg::ST_IDLE: begin
				if (take && req.op == nand_host_pkg::OP_STOP)
					next_state = nand_host_pkg::ST_STOP;
				else if (take && req.op == nand_host_pkg::OP_WAIT_READY)
					next_state = nand_host_pkg::ST_BUSY_WAIT;
				else if (take)
					next_state = nand_host_pkg::ST_STROBE_LOW;
			end
			nand_host_pkg::ST_STROBE_LOW: if (cnt_done) next_state = nand_host_pkg::ST_STROBE_HIGH;
			nand_host_pkg::ST_STROBE_HIGH: begin
				if (cnt_done) begin
					if (cur.op == nand_host_pkg::OP_ADDR && addr_idx != `ADDR_CYCLES - 3'h1)
						next_state = nand_host_pkg::ST_STROBE_LOW;
					else if (cur.op == nand_host_pkg::OP_RDATA && cur.last_of_page)
						next_state = nand_host_pkg::ST_BUSY_WAIT;
					else
						next_state = nand_host_pkg::ST_IDLE;
				end
			end
			nand_host_pkg::ST_BUSY_WAIT: if (cnt_done) next_state = nand_host_pkg::ST_READY_WAIT;
			nand_host_pkg::ST_READY_WAIT: if (ready_busy_out)
				next_state = nand_host_pkg::ST_IDLE;
			nand_host_pkg::ST_STOP: if (cnt_done) next_state = nand_host_pkg::ST_IDLE;
			default: next_state = nand_host_pkg::ST_IDLE;
		endcase
	end

	// ==========================================================
	// sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= nand_host_pkg::ST_IDLE;
			cnt <= '0;
			addr_idx <= 3'h0;
			cur <= '0;
		end else begin
			state <= next_state;
			if (take) begin
				cur <= req;
				addr_idx <= 3'h0;
			end else if (state == nand_host_pkg::ST_STROBE_HIGH && cnt_done)
				addr_idx <= addr_idx + 3'h1;
			if (!cnt_done)
				cnt <= cnt - `CNT_W'(1);
			else if (next_state == nand_host_pkg::ST_STOP)
				cnt <= `CNT_W'(`STOP_CYC - 1);
			else if (next_state == nand_host_pkg::ST_STROBE_LOW)
				cnt <= (req.op == nand_host_pkg::OP_RDATA || cur.op == nand_host_pkg::OP_RDATA)
					&& state == nand_host_pkg::ST_IDLE && req.op == nand_host_pkg::OP_RDATA
					? `CNT_W'(`RE_LOW_CYC - 1) : `CNT_W'(`WE_LOW_CYC - 1);
			else if (next_state == nand_host_pkg::ST_STROBE_HIGH)
				cnt <= cur.op == nand_host_pkg::OP_RDATA ? `CNT_W'(`RE_HIGH_CYC - 1)
					: `CNT_W'(`WE_HIGH_CYC - 1);
			else if (next_state == nand_host_pkg::ST_BUSY_WAIT)
				cnt <= `CNT_W'(`BUSY_WAIT_CYC - 1);
		end
	end

	// ==========================================================
	// page program counters and multi-block count
	generate
		for (genvar p = 0; p < `PAGES_PER_BLOCK; p++) begin : g_pc
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					prog_count[p] <= 2'h0;
				else if (take && is_erase_cmd)
					prog_count[p] <= 2'h0;
				else if (take && is_prog_cmd && page_sel == 5'(p))
					prog_count[p] <= prog_count[p] + 2'h1;
			end
		end
	endgenerate

	// blocks in the current multi-block sequence
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			block_count <= 3'h0;
		else if (take && is_multi_cmd)
			block_count <= block_count + 3'h1;
		else if (take && is_prog_cmd)
			block_count <= 3'h0;
	end

	// ==========================================================
	// pins and read data
	wire strobe_low = (state == nand_host_pkg::ST_STROBE_LOW);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins <= '{cmd_latch: 1'b0, addr_latch: 1'b0, select_n: 1'b1,
				write_strobe_n: 1'b1, read_strobe_n: 1'b1};
			io_out <= 8'h00;
			io_oe <= 1'b0;
		end else begin
			pins.cmd_latch <= (next_state == nand_host_pkg::ST_STROBE_LOW
				|| next_state == nand_host_pkg::ST_STROBE_HIGH)
				&& (take ? req.op : cur.op) == nand_host_pkg::OP_CMD;
			pins.addr_latch <= (next_state == nand_host_pkg::ST_STROBE_LOW
				|| next_state == nand_host_pkg::ST_STROBE_HIGH)
				&& (take ? req.op : cur.op) == nand_host_pkg::OP_ADDR;
			pins.select_n <= (next_state == nand_host_pkg::ST_STOP);
			pins.write_strobe_n <= !(next_state == nand_host_pkg::ST_STROBE_LOW
				&& (take ? req.op : cur.op) != nand_host_pkg::OP_RDATA);
			pins.read_strobe_n <= !(next_state == nand_host_pkg::ST_STROBE_LOW
				&& (take ? req.op : cur.op) == nand_host_pkg::OP_RDATA);
			io_oe <= (next_state == nand_host_pkg::ST_STROBE_LOW
				|| next_state == nand_host_pkg::ST_STROBE_HIGH) && (take ? is_write_op_req(req.op)
				: is_write_op);
			if (take)
				io_out <= req.op == nand_host_pkg::OP_ADDR ? addr_byte(req.addr, 3'h0) : req.data;
			else if (state == nand_host_pkg::ST_STROBE_HIGH && cnt_done)
				io_out <= addr_byte(cur.addr, addr_idx + 3'h1);
		end
	end

	// write-type op test for the incoming request
	function automatic logic is_write_op_req(input nand_host_pkg::op_t o);
		is_write_op_req = (o == nand_host_pkg::OP_CMD) || (o == nand_host_pkg::OP_ADDR)
			|| (o == nand_host_pkg::OP_WDATA);
	endfunction

	// read byte sampled at the end of the strobe low phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
			rdata_valid <= 1'b0;
			refused <= 1'b0;
		end else begin
			rdata_valid <= strobe_low && cnt_done && cur.op == nand_host_pkg::OP_RDATA;
			if (strobe_low && cnt_done && cur.op == nand_host_pkg::OP_RDATA)
				rdata <= io_in;
			refused <= refuse_now;
		end
	end
endmodule
`default_nettype wire

// [nand_host_regs.svh]
// Purpose: timing and encoding constants for the nand flash host sequencer
// Assumes: 200 MHz clock, 5 ns period
// Notes: times in ns, cycle counts derived
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH
`define CLK_NS 5
`define WE_LOW_NS 25
`define WE_HIGH_NS 25
`define RE_LOW_NS 35
`define RE_HIGH_NS 15
`define SELECT_HIGH_STOP_NS 100
`define LAST_READ_TO_BUSY_NS 200
`define CYC_MIN(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define CYC_MAX(ns) (((ns) / `CLK_NS) < 1 ? 1 : ((ns) / `CLK_NS))
`define WE_LOW_CYC `CYC_MIN(`WE_LOW_NS)
`define WE_HIGH_CYC `CYC_MIN(`WE_HIGH_NS)
`define RE_LOW_CYC `CYC_MIN(`RE_LOW_NS)
`define RE_HIGH_CYC `CYC_MIN(`RE_HIGH_NS)
`define STOP_CYC `CYC_MIN(`SELECT_HIGH_STOP_NS)
`define BUSY_WAIT_CYC `CYC_MIN(`LAST_READ_TO_BUSY_NS)
`define ADDR_CYCLES 3'h4
`define LAST_ADDR_MASK 8'h03
`define CMD_RESET 8'hff
`define CMD_STATUS 8'h70
`define CMD_STATUS_ALT 8'h71
`define CMD_PROG 8'h10
`define CMD_DUMMY_PROG 8'h11
`define CMD_MULTI_PROG 8'h15
`define CMD_ERASE_GO 8'hd0
`define PAGE_IDX_LO 9
`define PAGE_IDX_HI 13
`define PAGES_PER_BLOCK 32
`define PAGES_PER_BLOCK_MASK 5'h1f
`define MAX_PROG_PER_PAGE 2'h3
`define MAX_MULTI_BLOCKS 3'h4
`define CNT_W 8
`endif

// [nand_host_pkg.sv]
// Purpose: types for the nand flash host sequencer
// Assumes: nothing
// Notes: request and pin groups travel as packed structs
package nand_host_pkg;
	typedef enum logic [2:0] {
		OP_CMD = 3'h0,
		OP_ADDR = 3'h1,
		OP_WDATA = 3'h2,
		OP_RDATA = 3'h3,
		OP_WAIT_READY = 3'h4,
		OP_STOP = 3'h5
	} op_t;
	typedef struct packed {
		op_t op;
		logic [7:0] data;
		logic [25:0] addr;
		logic last_of_page;
	} req_t;
	typedef struct packed {
		logic cmd_latch;
		logic addr_latch;
		logic select_n;
		logic write_strobe_n;
		logic read_strobe_n;
	} pins_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_STROBE_LOW = 3'h1,
		ST_STROBE_HIGH = 3'h3,
		ST_BUSY_WAIT = 3'h2,
		ST_READY_WAIT = 3'h6,
		ST_STOP = 3'h7
	} state_t;
endpackage

// [nand_host_assertions.sv]
// Purpose: checker for the nand host pin sequencing
// Assumes: bound to nand_host, one clock domain
// Notes: helper counts track select, address bytes, dummy programs
`timescale 1ns/100ps
`default_nettype none
module nand_host_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire nand_host_pkg::pins_t pins,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic ready_busy_out,
	input wire logic refused
);
	logic ws_q;
	logic [7:0] hi_cnt;
	logic [1:0] a_cnt;
	logic [2:0] mb_cnt;
	wire ws_rise = pins.write_strobe_n && !ws_q;
	wire mb_end = io_out == 8'h10 || io_out == 8'h15;
	wire [2:0] next_mb = io_out == 8'h11 ? mb_cnt + 3'h1 : (mb_end ? 3'h0 : mb_cnt);
	// ==========
	// helper counts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ws_q <= 1'b1;
			hi_cnt <= 8'hff;
			a_cnt <= 2'h0;
			mb_cnt <= 3'h0;
		end else begin
			ws_q <= pins.write_strobe_n;
			hi_cnt <= pins.select_n ? hi_cnt + {7'h00, hi_cnt != 8'hff} : 8'h00;
			if (ws_rise && pins.addr_latch) a_cnt <= a_cnt + 2'h1;
			if (ws_rise && pins.cmd_latch) mb_cnt <= next_mb;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// properties
	a_strobe_low_five: assert property (
		$fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*5] ##1 pins.write_strobe_n)
		else $error("write strobe low phase wrong");
	a_bus_held_rise: assert property (
		$rose(pins.write_strobe_n) |-> $stable(io_out) && io_oe)
		else $error("bus not held at write strobe rise");
	a_stop_select_long: assert property ($fell(pins.select_n) |-> hi_cnt >= 8'h14)
		else $error("select high too short");
	a_last_addr_top: assert property (
		ws_rise && pins.addr_latch && a_cnt == 2'h3 |-> io_out[7:2] == 6'h00)
		else $error("fourth address byte top bits set");
	a_no_cmd_busy: assert property (
		$fell(pins.write_strobe_n) && pins.cmd_latch && !ready_busy_out
		|-> io_out == 8'hff || io_out == 8'h70 || io_out == 8'h71)
		else $error("command sent while busy");
	a_multi_limit: assert property (
		ws_rise && pins.cmd_latch && io_out == 8'h11 |-> mb_cnt < 3'h3)
		else $error("too many blocks in multi program");
	a_refused_pulse: assert property (refused |=> !refused)
		else $error("refused longer than one cycle");
endmodule
bind nand_host nand_host_assertions nand_host_assertions_inst (.clk(clk), .rst_n(rst_n),
	.pins(pins), .io_out(io_out), .io_oe(io_oe), .ready_busy_out(ready_busy_out),
	.refused(refused));
`default_nettype wire

// [nand_dev_model.sv]
// Purpose: behavioural nand flash device facing the host sequencer
// Assumes: strobes active low, busy line pulled up
// Notes: busy times shortened through parameters
`timescale 1ns/100ps
`default_nettype none
module nand_dev_model #(parameter int FETCH_NS = 25000, parameter int PROG_NS = 200000,
	parameter int DUMMY_NS = 2000, parameter int RST_NS = 6000, parameter int PAGE = 528) (
	input wire nand_host_pkg::pins_t pins,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	output logic [7:0] io_in,
	output logic ready_busy_out
);
	logic rb = 1'b1;
	logic rd_mode = 1'b0;
	int gen = 0;
	int na = 0;
	int cnt = 0;
	// start a busy period, the newest one wins
	task automatic go_busy(input int ns);
		int g;
		gen++;
		g = gen;
		rb = 1'b0;
		fork
			begin
				#(ns + 1); // off the clock edge so the host never races it
				if (g == gen) rb = 1'b1;
			end
		join_none
	endtask
	// ==========
	// commands and address bytes on write strobe rise
	always @(posedge pins.write_strobe_n) begin
		if (pins.cmd_latch) begin
			na = 0;
			case (io_out)
				8'h00, 8'h01, 8'h50: rd_mode = 1'b1;
				8'h80, 8'h60: rd_mode = 1'b0;
				8'h10, 8'h15, 8'hd0: go_busy(PROG_NS);
				8'h11: go_busy(DUMMY_NS);
				8'hff: go_busy(RST_NS);
				default: ;
			endcase
		end else if (pins.addr_latch) begin
			na++;
			cnt = 0;
			if (na == 4 && rd_mode) go_busy(FETCH_NS);
		end
	end
	// page end fetch unless select rose quickly
	always @(posedge pins.read_strobe_n) begin
		cnt++;
		if (cnt == PAGE) begin
			cnt = 0;
			#28; // just short of the select window, off the clock edge
			if (!pins.select_n && rd_mode) go_busy(FETCH_NS);
		end
	end
	// select high cuts a fetch, long high ends the read
	always @(posedge pins.select_n) begin
		if (!rb && rd_mode) go_busy(1000);
		#99; // select edges sit on clock edges, look just before
		if (pins.select_n) rd_mode = 1'b0;
	end
	assign ready_busy_out = rb;
	assign io_in = io_oe ? io_out : (!pins.read_strobe_n ? 8'(cnt) ^ 8'ha5 : ~(8'(cnt - 1) ^ 8'ha5));
endmodule
`default_nettype wire

// [nand_host_tb.sv]
// Purpose: self-checking bench for the nand host sequencer
// Assumes: device model with shortened busy times
// Notes: read bytes are noted in a queue and compared on rdata_valid
`timescale 1ns/100ps
`default_nettype none
module nand_host_tb;
	localparam int PG = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	nand_host_pkg::req_t req = '0;
	logic req_valid = 1'b0;
	logic req_ready, rdata_valid, refused, io_oe, ready_busy_out, device_busy, got;
	logic [7:0] rdata, io_out, io_in;
	logic [25:0] a = 26'h0;
	nand_host_pkg::pins_t pins;
	logic [7:0] exp_q[$];
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int seed = 32'h073d;
	always #2.5 clk = ~clk;
	nand_host nand_host_inst (.clk(clk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .refused(refused),
		.pins(pins), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
		.ready_busy_out(ready_busy_out), .device_busy(device_busy));
	nand_dev_model #(.FETCH_NS(2000), .PROG_NS(3000), .DUMMY_NS(400), .RST_NS(600), .PAGE(PG))
		nand_dev_model_inst (.pins(pins), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
		.ready_busy_out(ready_busy_out));
	// ==========
	// shared tasks
	task automatic check(input logic [7:0] e, input logic [7:0] s, input string what);
		tests_run++;
		if (e !== s) begin
			failures++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task tally_and_finish();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// offer a request at the falling edge; taken when ready stands at a rising edge
	task automatic send(input nand_host_pkg::op_t op, input logic [7:0] d, input logic l,
		output logic ok);
		@(negedge clk);
		req = '{op, d, a, l};
		req_valid = 1'b1;
		ok = 1'b0;
		repeat (4000) begin
			@(posedge clk);
			ok = req_ready === 1'b1;
			@(negedge clk);
			if (refused === 1'b1 || ok) break;
		end
		req_valid = 1'b0;
	endtask
	task automatic read_page();
		for (int k = 0; k < PG; k++) begin
			exp_q.push_back(8'(k) ^ 8'ha5);
			send(nand_host_pkg::OP_RDATA, 8'h00, k == PG - 1, got);
		end
	endtask
	task automatic prog(input logic [7:0] fin, output logic ok);
		send(nand_host_pkg::OP_CMD, 8'h80, 1'b0, ok);
		if (ok) send(nand_host_pkg::OP_ADDR, 8'h00, 1'b0, ok);
		if (ok) send(nand_host_pkg::OP_WDATA, 8'($random(seed)), 1'b0, ok);
		if (ok) send(nand_host_pkg::OP_CMD, fin, 1'b0, ok);
	endtask
	// compare each read byte with the oldest note, and bound the run
	always @(posedge clk) begin
		cycles++;
		if (rdata_valid === 1'b1)
			check(exp_q.size() ? exp_q.pop_front() : 8'hxx, rdata, "rdata");
		if (cycles == 40000) begin
			failures++;
			tally_and_finish();
		end
	end
	// ==========
	// main sequence
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		check(8'h07, {3'h0, pins}, "idle pins");
		a = 26'($random(seed));
		a[13:9] = 5'h00;
		send(nand_host_pkg::OP_CMD, 8'h00, 1'b0, got);
		send(nand_host_pkg::OP_ADDR, 8'h00, 1'b0, got);
		read_page();
		read_page();
		send(nand_host_pkg::OP_STOP, 8'h00, 1'b0, got);
		$display("test sequential read done");
		for (int n = 0; n < 4; n++) begin
			prog(8'h10, got);
			check({7'h00, n < 3}, {7'h00, got}, "program taken");
		end
		send(nand_host_pkg::OP_CMD, 8'h60, 1'b0, got);
		send(nand_host_pkg::OP_ADDR, 8'h00, 1'b0, got);
		send(nand_host_pkg::OP_CMD, 8'hd0, 1'b0, got);
		for (int n = 0; n < 4; n++) begin
			a = a + 26'h200;
			prog(8'h11, got);
			check({7'h00, n < 3}, {7'h00, got}, "dummy program taken");
		end
		prog(8'h15, got);
		check(8'h01, {7'h00, got}, "multi program taken");
		$display("test program limits done");
		prog(8'h10, got);
		send(nand_host_pkg::OP_CMD, 8'hff, 1'b0, got);
		check(8'h01, {7'h00, got}, "reset while busy");
		check(8'h01, {7'h00, device_busy}, "busy during reset");
		send(nand_host_pkg::OP_WAIT_READY, 8'h00, 1'b0, got);
		check(8'h00, {7'h00, device_busy}, "ready after reset");
		check(8'h00, 8'(exp_q.size()), "pending reads");
		$display("test reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
